// file: src/ppl_pkg.sv
// Shared constants for the programming port link
package ppl_pkg;
   // Async restart character rate
   localparam int BAUD_BPS = 2400;
   localparam int CLK_HZ = 200000000;
   localparam int BAUD_CYCLES = CLK_HZ / BAUD_BPS;
   // Boot firmware restart sequence
   localparam logic [7:0] RESTART_BYTE0 = 8'h80;
   localparam logic [7:0] RESTART_BYTE1 = 8'h24;
   localparam logic [7:0] RESTART_BYTE2 = 8'h80;
   // Reset pulse and the quiet delay after it, in clk cycles
   localparam int RESET_PULSE_CYCLES = 2000;
   localparam int RESTART_DELAY_CYCLES = 4000;
   // Clocked link: half period of the target-made clock, in clk cycles
   localparam int LINK_HALF_CYCLES = 8;
   // Pre-agreed gap between bytes when no handshake is used
   localparam int BYTE_GAP_CYCLES = 64;
   // Clock doubler limit, in kHz
   localparam int DOUBLER_MAX_KHZ = 29500;
   // Doubler code sets per silicon revision
   localparam logic [1:0] REV_FIRST = 2'h0;
   localparam logic [1:0] REV_SECOND = 2'h1;
   localparam logic [1:0] REV_THIRD = 2'h2;
   localparam int DATA_BITS = 8;
   localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
endpackage

// file: src/ppl_if.sv
// Pins between the target port and the host side converter
`timescale 1ns/1ps
`default_nettype none
interface ppl_if;
   logic resetN;        // Host DTR drives target active-low reset
   logic attnStatus;    // Target status / link clock, read as DSR
   logic serialATx;     // Target transmit line (port C line six)
   logic serialARx;     // Target receive line (port C line seven)
   logic bootModeZero;  // Boot mode pin zero, driven by host side
   logic bootModeOne;   // Boot mode pin one, driven by host side
   modport target
   (
      input resetN, bootModeZero, bootModeOne, serialARx,
      output attnStatus, serialATx
   );
   modport host
   (
      output resetN, bootModeZero, bootModeOne, serialARx,
      input attnStatus, serialATx
   );
endinterface
`default_nettype wire

// file: src/ppl_target.sv
// Target end of the programming port and alternate clocked link
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ppl_target
   import ppl_pkg::*;
#(
   parameter int HALF = LINK_HALF_CYCLES,
   parameter int GAP = BYTE_GAP_CYCLES,
   parameter bit USE_HANDSHAKE = 1'b1
)
(
   input wire logic clk,
   input wire logic rst_n,
   ppl_if.target port,
   input wire logic coldBootEnable,
   input wire logic altLinkEnable,
   input wire logic cableProbe,
   input wire logic breakpointHit,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   output logic txReady,
   output logic [7:0] rxByte,
   output logic rxValid,
   output logic programMode,
   output logic cableFound,
   output logic hostAttention,
   input wire logic [31:0] clockKhz,
   input wire logic doublerWanted,
   input wire logic [1:0] siliconRev,
   output logic doublerOn,
   output logic [1:0] doublerCode
);
   typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} ppl_state_t;
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] s0, s1, sRx;
   logic bootZero, bootOne, rxPin;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s0 <= 2'h0;
         s1 <= 2'h0;
         sRx <= 2'h3;
      end
      else
      begin
         s0 <= {s0[0], port.bootModeZero};
         s1 <= {s1[0], port.bootModeOne};
         sRx <= {sRx[0], port.serialARx};
      end
   end
   assign bootZero = s0[1];
   assign bootOne = s1[1];
   assign rxPin = sRx[1];
   // ----------------------------------------------------------------
   // Boot strap capture and cable detection
   // ----------------------------------------------------------------
   // Capture runs three cycles so the pin synchronisers have filled
   logic [2:0] bootAge;
   logic probeDrive;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bootAge <= 3'h0;
         programMode <= 1'b0;
         cableFound <= 1'b0;
         hostAttention <= 1'b0;
         probeDrive <= 1'b0;
      end
      else
      begin
         bootAge <= {bootAge[1:0], 1'b1};
         if (!bootAge[2])
            programMode <= bootZero & bootOne;
         probeDrive <= cableProbe & ~coldBootEnable;
         if (probeDrive & cableProbe)
            cableFound <= bootZero;
         hostAttention <= altLinkEnable & bootOne;
      end
   end
   // ----------------------------------------------------------------
   // Clocked link, target owns the clock
   // ----------------------------------------------------------------
   ppl_state_t state;
   logic [7:0] txSh, rxSh;
   logic [3:0] bitCnt;
   logic [15:0] tick;
   logic linkClk, txLine, tickDone, handshakeOk;
   assign tickDone = (tick == 16'(HALF - 1));
   // Handshake keeps the converter receiver from overrunning
   assign handshakeOk = USE_HANDSHAKE ? bootZero : 1'b1;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         txSh <= 8'h00;
         rxSh <= 8'h00;
         bitCnt <= 4'h0;
         tick <= 16'h0;
         linkClk <= 1'b1;
         txLine <= 1'b0;
         txReady <= 1'b0;
         rxValid <= 1'b0;
         rxByte <= 8'h00;
      end
      else
      begin
         rxValid <= 1'b0;
         tick <= tickDone ? 16'h0 : tick + 16'h1;
         case (state)
            ST_IDLE:
            begin
               linkClk <= 1'b1;
               tick <= 16'h0;
               txReady <= altLinkEnable & handshakeOk;
               if (txValid & txReady)
               begin
                  txSh <= txByte;
                  txReady <= 1'b0;
                  bitCnt <= 4'h0;
                  state <= ST_LOW;
               end
            end
            ST_LOW:
            if (tickDone)
            begin
               linkClk <= 1'b1;
               rxSh <= {rxPin, rxSh[7:1]};
               state <= ST_HIGH;
            end
            else
               txLine <= txSh[0];
            ST_HIGH:
            if (tickDone)
            begin
               txSh <= {1'b0, txSh[7:1]};
               if (bitCnt == BIT_COUNT_LAST)
               begin
                  rxByte <= rxSh;
                  rxValid <= 1'b1;
                  state <= ST_GAP;
               end
               else
               begin
                  bitCnt <= bitCnt + 4'h1;
                  linkClk <= 1'b0;
                  state <= ST_LOW;
               end
            end
            ST_GAP:
            if (tick == 16'(HALF - 1) && bitCnt == 4'hf)
               state <= ST_IDLE;
            else if (tickDone)
               bitCnt <= (GAP <= HALF) ? 4'hf : bitCnt + 4'h1;
            default: state <= ST_IDLE;
         endcase
         if (state == ST_IDLE && txValid & txReady)
            linkClk <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   logic txPin, statusPin;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txPin <= 1'b0;
         statusPin <= 1'b0;
      end
      else
      begin
         if (altLinkEnable)
            txPin <= txLine;
         else
            txPin <= coldBootEnable | probeDrive;
         statusPin <= altLinkEnable ? linkClk : breakpointHit;
      end
   end
   assign port.serialATx = txPin;
   assign port.attnStatus = statusPin;
   // ----------------------------------------------------------------
   // Clock doubler guard
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         doublerOn <= 1'b0;
         doublerCode <= 2'h0;
      end
      else
      begin
         doublerOn <= doublerWanted && clockKhz <= 32'(DOUBLER_MAX_KHZ);
         doublerCode <= (siliconRev == REV_SECOND) ? 2'h2 : 2'h1;
      end
   end
endmodule
`default_nettype wire

// file: src/ppl_host.sv
// Host end: reset pulse, restart string, and clocked link converter
`timescale 1ns/1ps
`default_nettype none
module ppl_host
   import ppl_pkg::*;
#(
   parameter int PULSE = RESET_PULSE_CYCLES,
   parameter int DELAY = RESTART_DELAY_CYCLES,
   parameter int BAUD = BAUD_CYCLES
)
(
   input wire logic clk,
   input wire logic rst_n,
   ppl_if.host port,
   input wire logic restartReq,
   input wire logic attentionReq,
   input wire logic cablePlugged,
   input wire logic [7:0] replyByte,
   output logic busy,
   output logic [7:0] msgByte,
   output logic msgValid,
   output logic targetStatus
);
   typedef enum {H_IDLE, H_RESET, H_WAIT, H_SEND} ppl_hstate_t;
   ppl_hstate_t st;
   logic [1:0] sClk, sTx;
   logic prevClk, linkClk, rise, fall;
   logic [31:0] cnt;
   logic [3:0] bitIdx;
   logic [1:0] byteIdx;
   logic [9:0] frame;
   logic [7:0] shIn, shOut;
   logic [3:0] nIn;
   logic rstLine, txLine, rxOut;
   logic [7:0] seqByte;
   // A clock still this long ends a cut or stray frame
   localparam int FRAME_IDLE = 4 * LINK_HALF_CYCLES;
   logic [7:0] idleCnt;
   assign linkClk = sClk[1];
   assign rise = linkClk & ~prevClk;
   assign fall = ~linkClk & prevClk;
   // restart byte that follows the current one
   assign seqByte = (byteIdx == 2'h0) ? RESTART_BYTE1 : RESTART_BYTE2;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sClk <= 2'h0;
         sTx <= 2'h0;
         prevClk <= 1'b0;
         idleCnt <= 8'h00;
         st <= H_IDLE;
         cnt <= 32'h0;
         bitIdx <= 4'h0;
         byteIdx <= 2'h0;
         frame <= 10'h3ff;
         rstLine <= 1'b1;
         txLine <= 1'b1;
         busy <= 1'b0;
         shIn <= 8'h00;
         shOut <= 8'h00;
         nIn <= 4'h0;
         msgByte <= 8'h00;
         msgValid <= 1'b0;
         targetStatus <= 1'b0;
         rxOut <= 1'b1;
      end
      else
      begin
         sClk <= {sClk[0], port.attnStatus};
         sTx <= {sTx[0], port.serialATx};
         prevClk <= linkClk;
         targetStatus <= linkClk;
         msgValid <= 1'b0;
         case (st)
            H_IDLE:
            if (restartReq)
            begin
               rstLine <= 1'b0;
               busy <= 1'b1;
               cnt <= 32'h0;
               st <= H_RESET;
            end
            H_RESET:
            begin
               cnt <= cnt + 32'h1;
               if (cnt == 32'(PULSE - 1))
               begin
                  rstLine <= 1'b1;
                  cnt <= 32'h0;
                  st <= H_WAIT;
               end
            end
            H_WAIT:
            begin
               cnt <= cnt + 32'h1;
               if (cnt == 32'(DELAY - 1))
               begin
                  cnt <= 32'h0;
                  byteIdx <= 2'h0;
                  bitIdx <= 4'h0;
                  frame <= {1'b1, RESTART_BYTE0, 1'b0};
                  st <= H_SEND;
               end
            end
            H_SEND:
            begin
               txLine <= frame[0];
               cnt <= cnt + 32'h1;
               if (cnt == 32'(BAUD - 1))
               begin
                  cnt <= 32'h0;
                  frame <= {1'b1, frame[9:1]};
                  bitIdx <= bitIdx + 4'h1;
                  if (bitIdx == 4'h9)
                  begin
                     bitIdx <= 4'h0;
                     if (byteIdx == 2'h2)
                     begin
                        busy <= 1'b0;
                        st <= H_IDLE;
                     end
                     else
                     begin
                        byteIdx <= byteIdx + 2'h1;
                        frame <= {1'b1, seqByte, 1'b0};
                     end
                  end
               end
            end
            default: st <= H_IDLE;
         endcase
         idleCnt <= (rise | fall) ? 8'h00 : idleCnt + 8'h01;
         if (idleCnt == 8'(FRAME_IDLE) && !(rise | fall))
         begin
            idleCnt <= idleCnt;
            nIn <= 4'h0;
         end
         // accept unsolicited bytes; sample on rise
         if (rise)
         begin
            shIn <= {sTx[1], shIn[7:1]};
            nIn <= (nIn == 4'h7) ? 4'h0 : nIn + 4'h1;
            if (nIn == 4'h7)
            begin
               msgByte <= {sTx[1], shIn[7:1]};
               msgValid <= 1'b1;
               shOut <= replyByte;
            end
         end
         if (fall)
         begin
            rxOut <= shOut[0];
            shOut <= {1'b0, shOut[7:1]};
         end
         // Reload only while the clock idles high, never inside a frame
         if (st == H_IDLE && nIn == 4'h0 && linkClk && !rise)
            shOut <= replyByte;
      end
   end
   assign port.resetN = rstLine;
   // boot pins low without cable, but attention raises pin one; pin zero also needs ready
   assign port.bootModeOne = cablePlugged | attentionReq;
   assign port.bootModeZero = cablePlugged & ~busy;
   assign port.serialARx = (st == H_SEND) ? txLine : rxOut;
endmodule
`default_nettype wire

// file: dv/ppl_chk.sv
// Interface checker for the programming port link
`timescale 1ns/1ps
`default_nettype none
module ppl_chk
#(
   parameter int PULSE = 20,
   parameter int HALF = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic resetN,
   input wire logic attnStatus,
   input wire logic serialATx,
   input wire logic serialARx,
   input wire logic bootModeZero,
   input wire logic bootModeOne
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   // Counted, not repeated: the pulse is longer than a repetition may be
   int lowCount;
   int stillCount;
   logic lastAttn;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lowCount <= 0;
         stillCount <= 0;
         lastAttn <= 1'b0;
      end
      else
      begin
         lowCount <= resetN ? 0 : lowCount + 1;
         stillCount <= (attnStatus != lastAttn) ? 0 : stillCount + 1;
         lastAttn <= attnStatus;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_pulse_width: assert property
      ($rose(resetN) |-> lowCount == PULSE)
      else $error("reset pulse width wrong");
   chk_pulse_min: assert property ($fell(resetN) |=> !resetN [*8])
      else $error("reset pulse too short");
   chk_quiet_delay: assert property
      ($rose(resetN) |=> $stable(serialARx) [*8])
      else $error("receive line moved during restart delay");
   chk_tx_after_reset: assert property ($rose(rst_n) |-> !serialATx)
      else $error("transmit line not low after reset");
   chk_reset_line_idle: assert property
      ($rose(rst_n) |-> resetN && !attnStatus)
      else $error("reset or status line wrong after reset");
   chk_tx_at_rise: assert property
      ($rose(attnStatus) |-> $stable(serialATx))
      else $error("target data moved at clock rise");
   chk_rx_at_rise: assert property
      ($rose(attnStatus) |-> $stable(serialARx))
      else $error("host data moved at clock rise");
   chk_half_period: assert property
      ($changed(attnStatus) |-> stillCount >= HALF - 1)
      else $error("link clock half period too short");
   cover property ($rose(resetN));
   cover property ($fell(attnStatus) && serialATx);
   cover property ($rose(bootModeOne) && bootModeZero);
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Testbench joining both ends of the programming port link
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ppl_pkg::*;
;
   logic clk, rst_n, coldBootEnable, altLinkEnable, cableProbe;
   logic breakpointHit, txValid, txReady, rxValid, programMode;
   logic cableFound, hostAttention, doublerWanted, doublerOn;
   logic restartReq, attentionReq, cablePlugged, busy, msgValid;
   logic targetStatus;
   logic [7:0] txByte, rxByte, replyByte, msgByte;
   logic [31:0] clockKhz;
   logic [1:0] siliconRev, doublerCode, expCode;
   int n_errors, samples_checked;
   wire [9:0] watch;
   ppl_if link();
   assign watch = {~link.serialARx, ~link.resetN, cableFound, targetStatus,
      hostAttention, txReady, rxValid, msgValid, ~busy, busy};
   ppl_target ppl_target_i (.clk(clk), .rst_n(rst_n), .port(link),
      .coldBootEnable(coldBootEnable), .altLinkEnable(altLinkEnable),
      .cableProbe(cableProbe), .breakpointHit(breakpointHit),
      .txByte(txByte), .txValid(txValid), .txReady(txReady),
      .rxByte(rxByte), .rxValid(rxValid), .programMode(programMode),
      .cableFound(cableFound), .hostAttention(hostAttention),
      .clockKhz(clockKhz), .doublerWanted(doublerWanted),
      .siliconRev(siliconRev), .doublerOn(doublerOn),
      .doublerCode(doublerCode));
   ppl_host #(.PULSE(20), .DELAY(40), .BAUD(16)) ppl_host_i (.clk(clk),
      .rst_n(rst_n), .port(link), .restartReq(restartReq),
      .attentionReq(attentionReq), .cablePlugged(cablePlugged),
      .replyByte(replyByte), .busy(busy), .msgByte(msgByte),
      .msgValid(msgValid), .targetStatus(targetStatus));
   ppl_chk #(.PULSE(20), .HALF(8)) ppl_chk_i (.clk(clk), .rst_n(rst_n),
      .resetN(link.resetN), .attnStatus(link.attnStatus),
      .serialATx(link.serialATx), .serialARx(link.serialARx),
      .bootModeZero(link.bootModeZero), .bootModeOne(link.bootModeOne));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task end_of_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: byte %h not %h", $time, got, exp);
      end
   endtask
   // Bounded wait on one watched flag, sampled at falling edges
   task automatic wait_bit(input int idx, input int bound);
      int n;
      n = 0;
      while (watch[idx] !== 1'b1 && n < bound)
      begin
         @(negedge clk);
         n++;
      end
      if (watch[idx] !== 1'b1)
      begin
         n_errors++;
         $display("wrong value at %0t: wait %0d timed out", $time, idx);
         end_of_test;
      end
   endtask
   // Samples one async character mid-bit, 16 clocks a bit
   task automatic uart_get(input logic [7:0] exp);
      logic [7:0] b;
      b = 8'h00;
      wait_bit(9, 400);
      repeat (8) @(negedge clk);
      repeat (8)
      begin
         repeat (16) @(negedge clk);
         b = {link.serialARx, b[7:1]};
      end
      repeat (16) @(negedge clk);
      cmp_byte(b, exp);
   endtask
   task do_reset;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
   endtask
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      n_errors = 0;
      samples_checked = 0;
      {rst_n, coldBootEnable, altLinkEnable, cableProbe} = 4'h0;
      {breakpointHit, txValid, restartReq, attentionReq} = 4'h0;
      {cablePlugged, doublerWanted} = 2'h0;
      txByte = 8'h00;
      replyByte = 8'h00;
      clockKhz = 32'h0;
      siliconRev = 2'h0;
      do_reset;
      cmp_bit(link.serialATx, 1'b0);
      cmp_bit(link.resetN, 1'b1);
      cmp_bit(txReady, 1'b0);
      cmp_bit(programMode, 1'b0);
      cmp_bit(link.bootModeZero, 1'b0);
      cmp_bit(busy, 1'b0);
      cablePlugged = 1'b1;
      attentionReq = 1'b1;
      do_reset;
      cmp_bit(programMode, 1'b1);
      cableProbe = 1'b1;
      wait_bit(7, 50);
      cmp_bit(link.serialATx, 1'b1);
      cableProbe = 1'b0;
      repeat (4) @(negedge clk);
      // Link on early: the host drops the stray rise as an idle frame
      altLinkEnable = 1'b1;
      wait_bit(5, 20);
      attentionReq = 1'b0;
      restartReq = 1'b1;
      wait_bit(8, 50);
      restartReq = 1'b0;
      cmp_bit(busy, 1'b1);
      uart_get(RESTART_BYTE0);
      uart_get(RESTART_BYTE1);
      uart_get(RESTART_BYTE2);
      wait_bit(1, 200);
      doublerWanted = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         clockKhz = (i == 3) ? 32'd29501 : 32'd29500;
         siliconRev = (i > 2) ? REV_SECOND : i[1:0];
         doublerWanted = (i != 4);
         expCode = (siliconRev === REV_SECOND) ? 2'h2 : 2'h1;
         repeat (3) @(negedge clk);
         cmp_bit(doublerOn, i < 3);
         if (i < 3)
            cmp_byte({6'h00, doublerCode}, {6'h00, expCode});
      end
      for (int i = 0; i < 2; i++)
      begin
         txByte = (i == 0) ? 8'ha5 : 8'h01;
         replyByte = (i == 0) ? 8'h5a : 8'h80;
         txValid = 1'b1;
         wait_bit(4, 400);
         @(negedge clk);
         txValid = 1'b0;
         fork
            wait_bit(3, 400);
            wait_bit(2, 600);
         join
         cmp_byte(rxByte, replyByte);
         cmp_byte(msgByte, txByte);
      end
      altLinkEnable = 1'b0;
      repeat (20) @(negedge clk);
      breakpointHit = 1'b1;
      wait_bit(6, 50);
      repeat (10) @(negedge clk);
      breakpointHit = 1'b0;
      repeat (20) @(negedge clk);
      end_of_test;
   end
endmodule
`default_nettype wire
